// [rtl/vgc_consts.svh]
`ifndef VGC_CONSTS_SVH
`define VGC_CONSTS_SVH

// I/O port addresses
`define VGC_INDEX_PORT      16'h03ce
`define VGC_DATA_PORT       16'h03cf

// Index values of the indexed registers
`define VGC_IDX_FILL_COLOR  4'h0
`define VGC_IDX_FILL_EN     4'h1
`define VGC_IDX_CMP_COLOR   4'h2
`define VGC_IDX_LOGIC_ROT   4'h3
`define VGC_IDX_READ_PLANE  4'h4
`define VGC_IDX_MODE        4'h5
`define VGC_IDX_MEMMAP      4'h6
`define VGC_IDX_CMP_MASK    4'h7
`define VGC_IDX_BIT_MASK    4'h8

// Field positions
`define VGC_ROT_LSB         0
`define VGC_ROT_MSB         2
`define VGC_LOP_LSB         3
`define VGC_LOP_MSB         4
`define VGC_WMODE_LSB       0
`define VGC_WMODE_MSB       1
`define VGC_CMP_BIT         3
`define VGC_OE_BIT          4
`define VGC_SHF_BIT         5
`define VGC_256_BIT         6

// Writable bit masks; other bits read as zero
`define VGC_MASK_INDEX      8'h0f
`define VGC_MASK_NIBBLE     8'h0f
`define VGC_MASK_LOGIC_ROT  8'h1f
`define VGC_MASK_READ_PLANE 8'h03
`define VGC_MASK_MODE       8'h7b
`define VGC_MASK_FULL       8'hff

// Reset values (power-on contents are undefined, so zero is used)
`define VGC_RESET_BYTE      8'h00

`endif

// [rtl/vgc_pkg.sv]
package vgc_pkg;

    typedef enum logic [1:0] {
        VGC_WM0 = 2'h0,
        VGC_WM1 = 2'h1,
        VGC_WM2 = 2'h2,
        VGC_WM3 = 2'h3
    } vgc_wmode_e;

    typedef enum logic [1:0] {
        VGC_LOP_PASS = 2'h0,
        VGC_LOP_AND  = 2'h1,
        VGC_LOP_OR   = 2'h2,
        VGC_LOP_XOR  = 2'h3
    } vgc_lop_e;

    typedef enum logic [1:0] {
        VGC_SHF_NORMAL = 2'h0,
        VGC_SHF_PAIRED = 2'h1,
        VGC_SHF_256    = 2'h2
    } vgc_shf_e;

    // Host I/O cycle
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } vgc_io_s;

    // Host memory cycle
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       a0;
        logic [7:0] wdata;
    } vgc_mem_s;

    typedef logic [31:0] vgc_planes_t;

endpackage

// [rtl/vgc_core.sv]
`timescale 1ns/1ps
`include "vgc_consts.svh"

// Behaviour
// - Index port holds 4-bit register index
// - Data port reaches the indexed register
// - Mode 0 substitutes fill color on enabled planes
// - Compare read returns per-pixel color match
// - Compare mask zero excludes that plane
// - Rotate field right-rotates CPU write byte
// - Logic op: pass, AND, OR, XOR
// - Logic op applies except write mode 1
// - Read mode 0 returns chosen plane byte
// - Odd/even ignores read plane low bit
// - Mode 0: rotate, fill, logic op, mask
// - Mode 1 writes latches, bypasses everything
// - Memory reads load the four latches
// - Mode 2 replicates CPU bits 0-3 per plane
// - Mode 2 mask picks bus color or latch
// - Mask zero keeps latch, one allows value
// - Mode 3 fills color, mask is rotated AND mask
// - Mode bit 3 selects compare reads
// - Odd/even maps even/odd addresses to planes
// - Bit 5 selects paired-plane shift format
// - Bit 6 selects 256-color format, overrides 5
module vgc_core (
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire vgc_pkg::vgc_io_s   io_req,
    input  wire vgc_pkg::vgc_mem_s  mem_req,
    input  wire logic [31:0]        plane_rdata,
    output logic [7:0]              io_rdata,
    output logic [7:0]              mem_rdata,
    output logic [31:0]             plane_wdata,
    output logic [3:0]              plane_wen,
    output logic [1:0]              serializer_format,
    output logic                    odd_even_active,
    output logic [1:0]              memory_map_sel,
    output logic                    chain_odd_even,
    output logic                    graphics_mode
);
    import vgc_pkg::*;

    // =========================================================
    // Register file
    // =========================================================
    logic [7:0] graphics_index_port;
    logic [7:0] fill_color_planes;
    logic [7:0] fill_color_enables;
    logic [7:0] compare_reference_color;
    logic [7:0] logic_op_and_rotation;
    logic [7:0] read_plane_choice;
    logic [7:0] plane_access_mode;
    logic [7:0] memory_map_ctrl;
    logic [7:0] compare_plane_mask;
    logic [7:0] bit_mask;
    // Processor latches, one byte per plane
    logic [31:0] latch;

    logic       idx_wr;
    logic       dat_wr;
    logic [3:0] cur_idx;
    logic [7:0] wd;
    logic [7:0] next_rd_byte;

    // Host strobes decoded once; every host-written register below keys off them
    assign idx_wr  = io_req.wr && (io_req.addr == `VGC_INDEX_PORT);
    assign dat_wr  = io_req.wr && (io_req.addr == `VGC_DATA_PORT);
    assign cur_idx = graphics_index_port[3:0];
    assign wd      = io_req.wdata;

    // Index register: low nibble only, upper bits stay zero
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            graphics_index_port <= `VGC_RESET_BYTE;
        end else if (idx_wr) begin
            graphics_index_port <= wd & `VGC_MASK_INDEX;
        end
    end

    // Fill color, one bit per plane; unused index values match nothing
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            fill_color_planes <= `VGC_RESET_BYTE;
        end else if (dat_wr && cur_idx == `VGC_IDX_FILL_COLOR) begin
            fill_color_planes <= wd & `VGC_MASK_NIBBLE;
        end
    end

    // Fill enables, one bit per plane
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            fill_color_enables <= `VGC_RESET_BYTE;
        end else if (dat_wr && cur_idx == `VGC_IDX_FILL_EN) begin
            fill_color_enables <= wd & `VGC_MASK_NIBBLE;
        end
    end

    // Compare reference color
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            compare_reference_color <= `VGC_RESET_BYTE;
        end else if (dat_wr && cur_idx == `VGC_IDX_CMP_COLOR) begin
            compare_reference_color <= wd & `VGC_MASK_NIBBLE;
        end
    end

    // Logic function and rotate count
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            logic_op_and_rotation <= `VGC_RESET_BYTE;
        end else if (dat_wr && cur_idx == `VGC_IDX_LOGIC_ROT) begin
            logic_op_and_rotation <= wd & `VGC_MASK_LOGIC_ROT;
        end
    end

    // Read plane choice
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            read_plane_choice <= `VGC_RESET_BYTE;
        end else if (dat_wr && cur_idx == `VGC_IDX_READ_PLANE) begin
            read_plane_choice <= wd & `VGC_MASK_READ_PLANE;
        end
    end

    // Mode register; bits 2 and 7 are reserved and stay zero
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            plane_access_mode <= `VGC_RESET_BYTE;
        end else if (dat_wr && cur_idx == `VGC_IDX_MODE) begin
            plane_access_mode <= wd & `VGC_MASK_MODE;
        end
    end

    // Memory map control
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            memory_map_ctrl <= `VGC_RESET_BYTE;
        end else if (dat_wr && cur_idx == `VGC_IDX_MEMMAP) begin
            memory_map_ctrl <= wd & `VGC_MASK_NIBBLE;
        end
    end

    // Compare plane mask
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            compare_plane_mask <= `VGC_RESET_BYTE;
        end else if (dat_wr && cur_idx == `VGC_IDX_CMP_MASK) begin
            compare_plane_mask <= wd & `VGC_MASK_NIBBLE;
        end
    end

    // Bit mask, all eight bits writable
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            bit_mask <= `VGC_RESET_BYTE;
        end else if (dat_wr && cur_idx == `VGC_IDX_BIT_MASK) begin
            bit_mask <= wd & `VGC_MASK_FULL;
        end
    end

    // =========================================================
    // Field decode
    // =========================================================
    logic [2:0] rot_count;
    vgc_lop_e   latch_logic_function;
    vgc_wmode_e write_mode_field;
    logic       compare_read_select;
    logic       odd_even_map;

    // Fields are decoded combinationally so a write takes effect at once
    assign rot_count            =
        logic_op_and_rotation[`VGC_ROT_MSB:`VGC_ROT_LSB];
    assign latch_logic_function =
        vgc_lop_e'(logic_op_and_rotation[`VGC_LOP_MSB:`VGC_LOP_LSB]);
    assign write_mode_field     =
        vgc_wmode_e'(plane_access_mode[`VGC_WMODE_MSB:`VGC_WMODE_LSB]);
    assign compare_read_select  = plane_access_mode[`VGC_CMP_BIT];
    assign odd_even_map         = plane_access_mode[`VGC_OE_BIT];

    // =========================================================
    // Write datapath
    // =========================================================
    logic [7:0]  rotated;
    logic [15:0] rot_dbl;
    logic [7:0]  eff_mask;
    logic [31:0] next_wdata;
    logic [3:0]  next_wen;

    // Right rotate by doubling the byte and slicing a window
    assign rot_dbl = {mem_req.wdata, mem_req.wdata} >> rot_count;
    assign rotated = rot_dbl[7:0];

    // Mode 3 narrows the mask by the rotated byte
    assign eff_mask = (write_mode_field == VGC_WM3) ?
                      (rotated & bit_mask) : bit_mask;

    // Per-plane source selection, logic op and masking
    for (genvar p = 0; p < 4; p++) begin : g_plane
        logic [7:0] src;
        logic [7:0] lat;
        logic [7:0] opd;
        logic [7:0] res;
        assign lat = latch[8*p +: 8];
        // One driver per plane slice of the next write word
        assign next_wdata[8*p +: 8] = res;
        always_comb begin
            src = rotated;
            unique case (write_mode_field)
                VGC_WM0: src = fill_color_enables[p] ?
                               {8{fill_color_planes[p]}} : rotated;
                VGC_WM1: src = lat;
                VGC_WM2: src = {8{mem_req.wdata[p]}};
                VGC_WM3: src = {8{fill_color_planes[p]}};
            endcase
            unique case (latch_logic_function)
                VGC_LOP_PASS: opd = src;
                VGC_LOP_AND:  opd = src & lat;
                VGC_LOP_OR:   opd = src | lat;
                VGC_LOP_XOR:  opd = src ^ lat;
            endcase
            if (write_mode_field == VGC_WM1) begin
                res = lat;
            end else begin
                // Mask zero keeps the latched pixel
                res = (opd & eff_mask) | (lat & ~eff_mask);
            end
        end
    end

    // Odd/even: even address reaches planes 0/2, odd reaches 1/3
    assign next_wen = !mem_req.wr ? 4'h0 :
                      !odd_even_map ? 4'hf :
                      (mem_req.a0 ? 4'ha : 4'h5);

    // Plane write strobe and data, registered
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            plane_wdata <= 32'h0;
            plane_wen   <= 4'h0;
        end else begin
            plane_wdata <= next_wdata;
            plane_wen   <= next_wen;
        end
    end

    // =========================================================
    // Read datapath
    // =========================================================
    logic [1:0] rd_plane;
    logic [7:0] cmp_result;
    logic [7:0] next_mem_rdata;

    // Compare mode ignores the plane choice entirely
    // Odd/even takes the plane's low bit from the address instead
    assign rd_plane = odd_even_map ?
                      {read_plane_choice[1], mem_req.a0} :
                      read_plane_choice[1:0];

    // Per pixel: masked planes must all match the reference color
    for (genvar b = 0; b < 8; b++) begin : g_cmp
        logic [3:0] pix;
        assign pix = {plane_rdata[24+b], plane_rdata[16+b],
                      plane_rdata[8+b], plane_rdata[b]};
        assign cmp_result[b] = ~|((pix ^ compare_reference_color[3:0])
                                  & compare_plane_mask[3:0]);
    end

    assign next_mem_rdata = compare_read_select ? cmp_result :
                            plane_rdata[8*rd_plane +: 8];

    // Latches load from memory on every CPU read
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            latch     <= 32'h0;
            mem_rdata <= `VGC_RESET_BYTE;
        end else if (mem_req.rd) begin
            latch     <= plane_rdata;
            mem_rdata <= next_mem_rdata;
        end
    end

    // I/O read data mux
    always_comb begin
        next_rd_byte = `VGC_RESET_BYTE;
        if (io_req.addr == `VGC_INDEX_PORT) begin
            next_rd_byte = graphics_index_port;
        end else if (io_req.addr == `VGC_DATA_PORT) begin
            case (graphics_index_port[3:0])
                `VGC_IDX_FILL_COLOR: next_rd_byte = fill_color_planes;
                `VGC_IDX_FILL_EN:    next_rd_byte = fill_color_enables;
                `VGC_IDX_CMP_COLOR:  next_rd_byte = compare_reference_color;
                `VGC_IDX_LOGIC_ROT:  next_rd_byte = logic_op_and_rotation;
                `VGC_IDX_READ_PLANE: next_rd_byte = read_plane_choice;
                `VGC_IDX_MODE:       next_rd_byte = plane_access_mode;
                `VGC_IDX_MEMMAP:     next_rd_byte = memory_map_ctrl;
                `VGC_IDX_CMP_MASK:   next_rd_byte = compare_plane_mask;
                `VGC_IDX_BIT_MASK:   next_rd_byte = bit_mask;
                default:             next_rd_byte = `VGC_RESET_BYTE;
            endcase
        end
    end

    // Read data holds until the next I/O read
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            io_rdata <= `VGC_RESET_BYTE;
        end else if (io_req.rd) begin
            io_rdata <= next_rd_byte;
        end
    end

    // =========================================================
    // Serializer and addressing controls
    // =========================================================
    // Bit 6 wins over bit 5 so 256-color loads are never paired
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            serializer_format <= VGC_SHF_NORMAL;
        end else if (plane_access_mode[`VGC_256_BIT]) begin
            serializer_format <= VGC_SHF_256;
        end else if (plane_access_mode[`VGC_SHF_BIT]) begin
            serializer_format <= VGC_SHF_PAIRED;
        end else begin
            serializer_format <= VGC_SHF_NORMAL;
        end
    end

    // Addressing levels lag their register by one cycle
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            odd_even_active   <= 1'b0;
            memory_map_sel    <= 2'h0;
            chain_odd_even    <= 1'b0;
            graphics_mode     <= 1'b0;
        end else begin
            odd_even_active <= odd_even_map;
            memory_map_sel  <= memory_map_ctrl[3:2];
            chain_odd_even  <= memory_map_ctrl[1];
            graphics_mode   <= memory_map_ctrl[0];
        end
    end

endmodule

// [tb/vgc_core_properties.sv]
`timescale 1ns/1ps
`include "vgc_consts.svh"

// ==========================================
// Port checker for the graphics datapath
module vgc_core_properties (
    input wire logic               ref_clk,
    input wire logic               resetn,
    input wire vgc_pkg::vgc_io_s   io_req,
    input wire vgc_pkg::vgc_mem_s  mem_req,
    input wire logic [7:0]         io_rdata,
    input wire logic [7:0]         mem_rdata,
    input wire logic [3:0]         plane_wen,
    input wire logic [1:0]         serializer_format,
    input wire logic               odd_even_active
);
    import vgc_pkg::*;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Mode register write: index cycle, then data cycle right behind it
    sequence s_pick_mode;
        io_req.wr && io_req.addr == `VGC_INDEX_PORT
            && io_req.wdata[3:0] == `VGC_IDX_MODE;
    endsequence
    sequence s_fill_data;
        io_req.wr && io_req.addr == `VGC_DATA_PORT;
    endsequence

    property p_wen_full;
        mem_req.wr && !odd_even_active |=> plane_wen == 4'hf;
    endproperty
    a_wen_full: assert property (p_wen_full)
        else $error("write did not reach all planes");
    property p_wen_even;
        mem_req.wr && odd_even_active && !mem_req.a0 |=> plane_wen == 4'h5;
    endproperty
    a_wen_even: assert property (p_wen_even)
        else $error("even address strobe wrong");
    property p_wen_odd;
        mem_req.wr && odd_even_active && mem_req.a0 |=> plane_wen == 4'ha;
    endproperty
    a_wen_odd: assert property (p_wen_odd)
        else $error("odd address strobe wrong");
    // Strobe is a single pulse, never a stale level
    property p_wen_idle;
        !mem_req.wr |=> plane_wen == 4'h0;
    endproperty
    a_wen_idle: assert property (p_wen_idle)
        else $error("plane strobe without write");
    property p_io_hold;
        !io_req.rd |=> $stable(io_rdata);
    endproperty
    a_io_hold: assert property (p_io_hold)
        else $error("register read data moved");
    property p_mem_hold;
        !mem_req.rd |=> $stable(mem_rdata);
    endproperty
    a_mem_hold: assert property (p_mem_hold)
        else $error("memory read data moved");
    property p_idx_rsvd;
        io_req.rd && io_req.addr == `VGC_INDEX_PORT |=> io_rdata[7:4] == 4'h0;
    endproperty
    a_idx_rsvd: assert property (p_idx_rsvd)
        else $error("index upper bits not zero");
    property p_foreign;
        io_req.rd && io_req.addr != `VGC_INDEX_PORT
            && io_req.addr != `VGC_DATA_PORT |=> io_rdata == 8'h00;
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("foreign port returned data");
    // Levels follow the mode register one cycle after it is written
    property p_shift_fmt;
        s_pick_mode ##1 s_fill_data |=> ##1 serializer_format ==
            ($past(io_req.wdata[6], 2) ? 2'h2 :
             {1'b0, $past(io_req.wdata[5], 2)});
    endproperty
    a_shift_fmt: assert property (p_shift_fmt)
        else $error("shift format wrong");
    property p_oe_field;
        s_pick_mode ##1 s_fill_data |=> ##1
            odd_even_active == $past(io_req.wdata[4], 2);
    endproperty
    a_oe_field: assert property (p_oe_field)
        else $error("odd/even flag wrong");
endmodule

bind vgc_core vgc_core_properties u_props (
    .ref_clk(ref_clk), .resetn(resetn), .io_req(io_req),
    .mem_req(mem_req), .io_rdata(io_rdata), .mem_rdata(mem_rdata),
    .plane_wen(plane_wen), .serializer_format(serializer_format),
    .odd_even_active(odd_even_active)
);

// [tb/vgc_plane_mem.sv]
`timescale 1ns/1ps

// ==========================================
// One location of four-plane video memory
module vgc_plane_mem (
    input wire logic        ref_clk,
    input wire logic [3:0]  plane_wen,
    input wire logic [31:0] plane_wdata,
    input wire logic        load_en,
    input wire logic [31:0] load_data,
    output logic [31:0]     plane_rdata
);
    // Preload wins so the bench can set up plane contents directly
    always_ff @(posedge ref_clk) begin
        if (load_en) begin
            plane_rdata <= load_data;
        end else begin
            for (int p = 0; p < 4; p++) begin
                if (plane_wen[p]) begin
                    plane_rdata[8*p +: 8] <= plane_wdata[8*p +: 8];
                end
            end
        end
    end
endmodule

// [tb/vgc_core_test.sv]
`timescale 1ns/1ps
`include "vgc_consts.svh"

// ==========================================
// Bench for the graphics datapath
module vgc_core_test;
    import vgc_pkg::*;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        load_en;
    logic [31:0] load_data, plane_rdata, plane_wdata;
    logic [7:0]  io_rdata, mem_rdata;
    logic [3:0]  plane_wen;
    logic [1:0]  serializer_format;
    logic        odd_even_active;
    logic [1:0]  memory_map_sel;
    logic        chain_odd_even, graphics_mode;
    vgc_io_s     io_req;
    vgc_mem_s    mem_req;
    int          num_errors = 0;
    int          n_checks = 0;

    vgc_core uut (.ref_clk(ref_clk), .resetn(resetn), .io_req(io_req),
        .mem_req(mem_req), .plane_rdata(plane_rdata), .io_rdata(io_rdata),
        .mem_rdata(mem_rdata), .plane_wdata(plane_wdata),
        .plane_wen(plane_wen), .serializer_format(serializer_format),
        .odd_even_active(odd_even_active),
        .memory_map_sel(memory_map_sel),
        .chain_odd_even(chain_odd_even), .graphics_mode(graphics_mode));
    vgc_plane_mem mem (.ref_clk(ref_clk), .plane_wen(plane_wen),
        .plane_wdata(plane_wdata), .load_en(load_en),
        .load_data(load_data), .plane_rdata(plane_rdata));

    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    // ==========================================
    // Shared tasks; all driving happens on the falling edge
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task idle;
        @(negedge ref_clk);
        io_req = '0;
        mem_req = '0;
        load_en = 1'b0;
    endtask
    task io_cyc(input logic rd, wr, input logic [15:0] a,
            input logic [7:0] d);
        @(negedge ref_clk);
        io_req = '{rd, wr, a, d};
    endtask
    // Index first, data right behind it
    task regw(input logic [3:0] idx, input logic [7:0] d);
        io_cyc(1'b0, 1'b1, `VGC_INDEX_PORT, {4'h0, idx});
        io_cyc(1'b0, 1'b1, `VGC_DATA_PORT, d);
        idle;
    endtask
    task regr(input logic [3:0] idx);
        io_cyc(1'b0, 1'b1, `VGC_INDEX_PORT, {4'h0, idx});
        io_cyc(1'b1, 1'b0, `VGC_DATA_PORT, 8'h00);
        idle;
    endtask
    task mem_cyc(input logic rd, wr, a0, input logic [7:0] d);
        @(negedge ref_clk);
        mem_req = '{rd, wr, a0, d};
        idle;
    endtask
    task load(input logic [31:0] d);
        @(negedge ref_clk);
        load_en = 1'b1;
        load_data = d;
        idle;
    endtask
    function automatic logic [7:0] cmp_exp(input logic [31:0] pl,
            input logic [3:0] c, m);
        for (int i = 0; i < 8; i++) begin
            cmp_exp[i] = 1'b1;
            for (int p = 0; p < 4; p++)
                if (m[p] && pl[8*p+i] !== c[p]) cmp_exp[i] = 1'b0;
        end
    endfunction
    // Fill color 05, enables 03, bit mask 0f, rotate 2 are fixed here
    function automatic logic [31:0] calc(input logic [1:0] wm, op,
            input logic [7:0] d, input logic [31:0] lat);
        logic [15:0] dd;
        logic [7:0]  r, v, m, l;
        dd = {d, d} >> 2;
        r = dd[7:0];
        for (int p = 0; p < 4; p++) begin
            l = lat[8*p +: 8];
            m = (wm == 2'h3) ? (r & 8'h0f) : 8'h0f;
            v = (wm == 2'h2) ? {8{d[p]}} : {8{p[0] ? 1'b0 : 1'b1}};
            if (wm == 2'h0 && p > 1) v = r;
            if (op == 2'h1) v = v & l;
            if (op == 2'h2) v = v | l;
            if (op == 2'h3) v = v ^ l;
            calc[8*p +: 8] = (wm == 2'h1) ? l : (v & m) | (l & ~m);
        end
    endfunction

    // ==========================================
    // Scenarios
    task t_regs;
        logic [7:0] m [9];
        m = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7b, 8'h0f, 8'h0f, 8'hff};
        for (int i = 0; i < 9; i++) begin
            regw(i[3:0], 8'hff);
            regr(i[3:0]);
            chk(io_rdata, m[i]);
        end
        regw(4'h6, 8'h09);
        idle;
        chk({memory_map_sel, chain_odd_even, graphics_mode}, 4'h9);
        regw(4'h9, 8'hff);
        regr(4'h9);
        chk(io_rdata, 8'h00);
        io_cyc(1'b0, 1'b1, `VGC_INDEX_PORT, 8'h5a);
        io_cyc(1'b1, 1'b0, `VGC_INDEX_PORT, 8'h00);
        idle;
        chk(io_rdata, 8'h0a);
        io_cyc(1'b1, 1'b0, 16'h03cd, 8'h00);
        idle;
        chk(io_rdata, 8'h00);
    endtask
    task t_reads;
        load(32'h44332211);
        regw(4'h5, 8'h00);
        for (int p = 0; p < 4; p++) begin
            regw(4'h4, p[7:0]);
            mem_cyc(1'b1, 1'b0, 1'b0, 8'h00);
            chk(mem_rdata, 8'h11 * (p + 1));
        end
        regw(4'h5, 8'h10);
        regw(4'h4, 8'h03);
        mem_cyc(1'b1, 1'b0, 1'b0, 8'h00);
        chk(mem_rdata, 8'h33);
        mem_cyc(1'b1, 1'b0, 1'b1, 8'h00);
        chk(mem_rdata, 8'h44);
        load(32'h00aaccf0);
        regw(4'h5, 8'h08);
        regw(4'h2, 8'h03);
        regw(4'h4, 8'h02);
        for (int k = 0; k < 2; k++) begin
            regw(4'h7, k ? 8'h03 : 8'h0f);
            mem_cyc(1'b1, 1'b0, 1'b0, 8'h00);
            chk(mem_rdata, cmp_exp(32'h00aaccf0, 4'h3, k ? 4'h3 : 4'hf));
        end
    endtask
    task t_writes;
        load(32'h3cc3a55a);
        regw(4'h5, 8'h00);
        mem_cyc(1'b1, 1'b0, 1'b0, 8'h00);
        regw(4'h0, 8'h05);
        regw(4'h1, 8'h03);
        regw(4'h8, 8'h0f);
        for (int w = 0; w < 4; w++) begin
            for (int o = 0; o < 4; o++) begin
                regw(4'h3, {3'h0, o[1:0], 3'h2});
                regw(4'h5, {6'h0, w[1:0]});
                mem_cyc(1'b0, 1'b1, 1'b0, 8'h81);
                chk(plane_wen, 4'hf);
                chk(plane_wdata, calc(w[1:0], o[1:0], 8'h81, 32'h3cc3a55a));
            end
        end
        regw(4'h3, 8'h00);
        regw(4'h1, 8'h00);
        regw(4'h8, 8'hff);
        regw(4'h5, 8'h10);
        mem_cyc(1'b0, 1'b1, 1'b1, 8'h81);
        chk(plane_wen, 4'ha);
        chk(plane_wdata, {4{8'h81}});
        mem_cyc(1'b0, 1'b1, 1'b0, 8'h81);
        chk(plane_wen, 4'h5);
    endtask
    task t_shift;
        logic [7:0] md [4];
        logic [1:0] fmt [4];
        md = '{8'h30, 8'h60, 8'h40, 8'h00};
        fmt = '{2'h1, 2'h2, 2'h2, 2'h0};
        for (int i = 0; i < 4; i++) begin
            regw(4'h5, md[i]);
            // Format is registered one cycle after the mode register
            idle;
            chk(serializer_format, fmt[i]);
            chk(odd_even_active, md[i][4]);
        end
    endtask

    // Main sequence
    initial begin
        io_req = '0;
        mem_req = '0;
        load_en = 1'b0;
        load_data = '0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        t_regs;
        t_reads;
        t_writes;
        t_shift;
        close_out;
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #50000;
        num_errors++;
        close_out;
    end
endmodule
